// ### hw/lfc_defines.svh
// Register offsets, field positions and reset values of the line format block
`ifndef LFC_DEFINES_SVH
`define LFC_DEFINES_SVH

`define LFC_ADDR_W         3
`define LFC_OFF_DATA       3'h0
`define LFC_OFF_DIV_HI     3'h1
`define LFC_OFF_FEATURE    3'h2
`define LFC_OFF_LINE_FMT   3'h3
`define LFC_OFF_LINE_STAT  3'h4

`define LFC_DAE_BIT        7
`define LFC_BRK_BIT        6
`define LFC_PFORCE_BIT     5
`define LFC_PEVEN_BIT      4
`define LFC_PON_BIT        3
`define LFC_STOP_BIT       2
`define LFC_LEN_MSB        1
`define LFC_LEN_LSB        0

`define LFC_LINE_FMT_RESET 8'h00
`define LFC_REG_ZERO       8'h00

`define LFC_ST_RX_READY    0
`define LFC_ST_OVERRUN     1
`define LFC_ST_PAR_ERR     2
`define LFC_ST_FRM_ERR     3
`define LFC_ST_BRK_DET     4
`define LFC_ST_HOLD_EMPTY  5
`define LFC_ST_TX_IDLE     6

`define LFC_LAST_IDX_BASE  3'h4
`define LFC_LEN_FIVE       2'h0
`define LFC_HALVES_BIT     3'h2
`define LFC_HALVES_STOP1   3'h2
`define LFC_HALVES_STOP15  3'h3
`define LFC_HALVES_STOP2   3'h4
`define LFC_CNT_ONE        16'h0001
`define LFC_FULL_MASK      8'hff

`endif

// ### hw/lfc_pkg.sv
// Types of the line format block
package lfc_pkg;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
  } lfc_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT_HIGH
  } lfc_rx_state_t;

  typedef struct packed {
    logic [7:0]    line_fmt;
    logic [7:0]    div_lo;
    logic [7:0]    div_hi;
    logic [7:0]    feature;
    logic [7:0]    rdata;
    logic [7:0]    tx_hold;
    logic          tx_full;
    lfc_tx_state_t tx_st;
    logic [7:0]    tx_shift;
    logic [2:0]    tx_idx;
    logic [2:0]    tx_half;
    logic [15:0]   tx_cnt;
    logic          tx_par;
    logic          tx_bit;
    logic          serial_out;
    logic [2:0]    rx_sync;
    logic          rx_lvl;
    lfc_rx_state_t rx_st;
    logic [7:0]    rx_shift;
    logic [2:0]    rx_idx;
    logic [16:0]   rx_cnt;
    logic          rx_par_bad;
    logic          rx_allz;
    logic [7:0]    rx_data;
    logic          rx_ready;
    logic          overrun;
    logic          par_err;
    logic          frm_err;
    logic          brk_det;
  } lfc_state_t;

endpackage : lfc_pkg

// ### hw/lfc_line_format.sv
// Line format control with character transmitter and receiver
`timescale 1ns/100ps
`default_nettype none
`include "lfc_defines.svh"

// Function
// - Divisor access bit high maps divisor latch and feature register; low after reset.
// - Break force bit high holds the serial output at logic 0.
// - Break persists whatever else happens until software clears it; resets to 0.
// - Parity on, forced, odd select: parity bit is 1 both ways.
// - Parity on, forced, even select: parity bit is 0 both ways.
// - Unforced parity: even select 0 gives odd ones count, 1 gives even.
// - Parity on appends and checks a parity bit; off by reset sends none.
// - Stop select with word length sets stop bit count; resets to 0.
// - Length field sets data bit count equally for transmit and receive.
module lfc_line_format #(
  parameter logic [15:0] DIV_RESET = 16'h0001
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  // Register port
  input  wire logic [`LFC_ADDR_W-1:0]   reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [7:0]               reg_rdata,
  // Serial line
  input  wire logic                     serial_in,
  output logic                          serial_out
);
  import lfc_pkg::*;

  lfc_state_t q_ff;
  lfc_state_t nxt_q;

  logic        dae;
  logic        pon;
  logic [1:0]  len_sel;
  logic [2:0]  last_idx;
  logic [7:0]  len_mask;
  logic [15:0] half_per;
  logic [16:0] full_per;
  logic [2:0]  stop_halves;
  logic [7:0]  status;
  // Timing strobes and the host's take of a received byte
  logic        host_takes_rx;
  logic        tx_half_done;
  logic        tx_bit_done;
  logic        rx_tick;
  logic [15:0] div_word;

  // Expected parity of masked data under the current format
  function automatic logic exp_parity(input logic [7:0] fmt, input logic [7:0] d);
    logic p;
    p = 1'b0;
    if (fmt[`LFC_PFORCE_BIT]) begin
      p = ~fmt[`LFC_PEVEN_BIT];
    end else if (fmt[`LFC_PEVEN_BIT]) begin
      p = ^d;
    end else begin
      p = ~(^d);
    end
    return p;
  endfunction : exp_parity

  always_comb begin
    dae      = q_ff.line_fmt[`LFC_DAE_BIT];
    pon      = q_ff.line_fmt[`LFC_PON_BIT];
    len_sel  = q_ff.line_fmt[`LFC_LEN_MSB:`LFC_LEN_LSB];
    last_idx = `LFC_LAST_IDX_BASE + {1'b0, len_sel};
    len_mask = `LFC_FULL_MASK >> (2'h3 - len_sel);
    div_word = {q_ff.div_hi, q_ff.div_lo};
    // A zero divisor would stall both engines, so it counts as one
    if (div_word == 16'h0000) begin
      half_per = `LFC_CNT_ONE;
    end else begin
      half_per = div_word;
    end
    full_per = {half_per, 1'b0};
    host_takes_rx = reg_rd && (reg_addr == `LFC_OFF_DATA) && !dae;
    tx_half_done  = (q_ff.tx_cnt == 16'h0000);
    tx_bit_done   = tx_half_done && (q_ff.tx_half == 3'h1);
    rx_tick       = (q_ff.rx_cnt == 17'h0_0000);
    // Half-bit granularity is what makes the 1.5 stop bit possible
    if (!q_ff.line_fmt[`LFC_STOP_BIT]) begin
      stop_halves = `LFC_HALVES_STOP1;
    end else if (len_sel == `LFC_LEN_FIVE) begin
      stop_halves = `LFC_HALVES_STOP15;
    end else begin
      stop_halves = `LFC_HALVES_STOP2;
    end
    status = `LFC_REG_ZERO;
    status[`LFC_ST_RX_READY]   = q_ff.rx_ready;
    status[`LFC_ST_OVERRUN]    = q_ff.overrun;
    status[`LFC_ST_PAR_ERR]    = q_ff.par_err;
    status[`LFC_ST_FRM_ERR]    = q_ff.frm_err;
    status[`LFC_ST_BRK_DET]    = q_ff.brk_det;
    status[`LFC_ST_HOLD_EMPTY] = ~q_ff.tx_full;
    status[`LFC_ST_TX_IDLE]    = (q_ff.tx_st == TX_IDLE);

    nxt_q = q_ff;
    nxt_q.rdata = `LFC_REG_ZERO;

    // Register reads; clears come before hardware sets below so sets win
    if (reg_rd) begin
      case (reg_addr)
        `LFC_OFF_DATA: begin
          if (dae) begin
            nxt_q.rdata = q_ff.div_lo;
          end else begin
            nxt_q.rdata    = q_ff.rx_data;
            nxt_q.rx_ready = 1'b0;
          end
        end
        `LFC_OFF_DIV_HI:    nxt_q.rdata = dae ? q_ff.div_hi : `LFC_REG_ZERO;
        `LFC_OFF_FEATURE:   nxt_q.rdata = dae ? q_ff.feature : `LFC_REG_ZERO;
        `LFC_OFF_LINE_FMT:  nxt_q.rdata = q_ff.line_fmt;
        `LFC_OFF_LINE_STAT: begin
          nxt_q.rdata   = status;
          nxt_q.overrun = 1'b0;
          nxt_q.par_err = 1'b0;
          nxt_q.frm_err = 1'b0;
          nxt_q.brk_det = 1'b0;
        end
        default:            nxt_q.rdata = `LFC_REG_ZERO;
      endcase
    end

    // Register writes; a data write while the holding slot is full is dropped
    if (reg_wr) begin
      case (reg_addr)
        `LFC_OFF_DATA: begin
          if (dae) begin
            nxt_q.div_lo = reg_wdata;
          end else if (!q_ff.tx_full) begin
            nxt_q.tx_hold = reg_wdata;
            nxt_q.tx_full = 1'b1;
          end
        end
        `LFC_OFF_DIV_HI: begin
          if (dae) begin
            nxt_q.div_hi = reg_wdata;
          end
        end
        `LFC_OFF_FEATURE: begin
          if (dae) begin
            nxt_q.feature = reg_wdata;
          end
        end
        `LFC_OFF_LINE_FMT:  nxt_q.line_fmt = reg_wdata;
        default: begin
        end
      endcase
    end

    // Transmitter
    if (q_ff.tx_st != TX_IDLE) begin
      if (tx_half_done) begin
        nxt_q.tx_cnt  = half_per - `LFC_CNT_ONE;
        nxt_q.tx_half = q_ff.tx_half - 3'h1;
      end else begin
        nxt_q.tx_cnt = q_ff.tx_cnt - `LFC_CNT_ONE;
      end
    end
    case (q_ff.tx_st)
      TX_IDLE: begin
        nxt_q.tx_bit = 1'b1;
        if (q_ff.tx_full) begin
          nxt_q.tx_full  = 1'b0;
          nxt_q.tx_shift = q_ff.tx_hold;
          nxt_q.tx_par   = exp_parity(q_ff.line_fmt, q_ff.tx_hold & len_mask);
          nxt_q.tx_bit   = 1'b0;
          nxt_q.tx_half  = `LFC_HALVES_BIT;
          nxt_q.tx_cnt   = half_per - `LFC_CNT_ONE;
          nxt_q.tx_st    = TX_START;
        end
      end
      TX_START, TX_DATA, TX_PAR, TX_STOP: begin
        if (tx_bit_done) begin
          nxt_q.tx_half = `LFC_HALVES_BIT;
          if (q_ff.tx_st == TX_START) begin
            nxt_q.tx_idx = 3'h0;
            nxt_q.tx_bit = q_ff.tx_shift[0];
            nxt_q.tx_st  = TX_DATA;
          end else if (q_ff.tx_st == TX_DATA && q_ff.tx_idx != last_idx) begin
            nxt_q.tx_idx = q_ff.tx_idx + 3'h1;
            nxt_q.tx_bit = q_ff.tx_shift[q_ff.tx_idx + 3'h1];
          end else if (q_ff.tx_st == TX_DATA && pon) begin
            nxt_q.tx_bit = q_ff.tx_par;
            nxt_q.tx_st  = TX_PAR;
          end else if (q_ff.tx_st != TX_STOP) begin
            nxt_q.tx_bit  = 1'b1;
            nxt_q.tx_half = stop_halves;
            nxt_q.tx_st   = TX_STOP;
          end else begin
            nxt_q.tx_bit = 1'b1;
            nxt_q.tx_st  = TX_IDLE;
          end
        end
      end
      default: nxt_q.tx_st = TX_IDLE;
    endcase
    // Break overrides the character engine, which keeps running underneath
    if (nxt_q.line_fmt[`LFC_BRK_BIT]) begin
      nxt_q.serial_out = 1'b0;
    end else begin
      nxt_q.serial_out = nxt_q.tx_bit;
    end

    // Receive synchroniser: a change is taken once stages two and three agree
    nxt_q.rx_sync = {q_ff.rx_sync[1:0], serial_in};
    if (q_ff.rx_sync[1] == q_ff.rx_sync[2]) begin
      nxt_q.rx_lvl = q_ff.rx_sync[2];
    end

    // Receiver samples mid-bit, timed from the start edge
    if (q_ff.rx_st != RX_IDLE && q_ff.rx_st != RX_WAIT_HIGH) begin
      if (rx_tick) begin
        nxt_q.rx_cnt = full_per - 17'h0_0001;
      end else begin
        nxt_q.rx_cnt = q_ff.rx_cnt - 17'h0_0001;
      end
    end
    case (q_ff.rx_st)
      RX_IDLE: begin
        if (!q_ff.rx_lvl) begin
          nxt_q.rx_cnt = {1'b0, half_per} - 17'h0_0001;
          nxt_q.rx_st  = RX_START;
        end
      end
      RX_START: begin
        if (q_ff.rx_cnt == 17'h0_0000) begin
          if (q_ff.rx_lvl) begin
            nxt_q.rx_st = RX_IDLE;                              // False start
          end else begin
            nxt_q.rx_idx   = 3'h0;
            nxt_q.rx_shift = `LFC_REG_ZERO;
            nxt_q.rx_allz  = 1'b1;
            nxt_q.rx_st    = RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (q_ff.rx_cnt == 17'h0_0000) begin
          nxt_q.rx_shift[q_ff.rx_idx] = q_ff.rx_lvl;
          nxt_q.rx_allz = q_ff.rx_allz & ~q_ff.rx_lvl;
          nxt_q.rx_par_bad = 1'b0;
          if (q_ff.rx_idx != last_idx) begin
            nxt_q.rx_idx = q_ff.rx_idx + 3'h1;
          end else begin
            nxt_q.rx_st = pon ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (q_ff.rx_cnt == 17'h0_0000) begin
          nxt_q.rx_par_bad = q_ff.rx_lvl != exp_parity(q_ff.line_fmt, q_ff.rx_shift);
          nxt_q.rx_allz    = q_ff.rx_allz & ~q_ff.rx_lvl;
          nxt_q.rx_st      = RX_STOP;
        end
      end
      RX_STOP: begin
        if (q_ff.rx_cnt == 17'h0_0000) begin
          nxt_q.rx_data  = q_ff.rx_shift;
          nxt_q.rx_ready = 1'b1;
          // Unread byte is lost; this set beats a status-read clear in the same cycle
          nxt_q.overrun  = nxt_q.overrun | (q_ff.rx_ready & ~host_takes_rx);
          nxt_q.par_err  = nxt_q.par_err | q_ff.rx_par_bad;
          nxt_q.frm_err  = nxt_q.frm_err | ~q_ff.rx_lvl;
          nxt_q.brk_det  = nxt_q.brk_det | (q_ff.rx_allz & ~q_ff.rx_lvl);
          // Only the first stop bit is checked; a low line must rise before rearming
          nxt_q.rx_st    = q_ff.rx_lvl ? RX_IDLE : RX_WAIT_HIGH;
        end
      end
      RX_WAIT_HIGH: begin
        if (q_ff.rx_lvl) begin
          nxt_q.rx_st = RX_IDLE;
        end
      end
      default: nxt_q.rx_st = RX_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q_ff            <= '0;
      q_ff.line_fmt   <= `LFC_LINE_FMT_RESET;
      q_ff.div_lo     <= DIV_RESET[7:0];
      q_ff.div_hi     <= DIV_RESET[15:8];
      q_ff.tx_bit     <= 1'b1;
      q_ff.serial_out <= 1'b1;
      q_ff.rx_sync    <= 3'h7;
      q_ff.rx_lvl     <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign reg_rdata  = q_ff.rdata;
  assign serial_out = q_ff.serial_out;

endmodule : lfc_line_format
`default_nettype wire

// ### tb/lfc_line_format_assertions.sv
// Port checks of the line format block
`timescale 1ns/100ps
`default_nettype none
module lfc_line_format_assertions #(
  parameter logic [15:0] DIV_RESET = 16'h0001
) (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_b,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Serial line
  input wire logic       serial_in,
  input wire logic       serial_out
);
  // Shadow of host writes and run lengths of the line
  logic [7:0] fmt_ff;
  logic [7:0] feat_ff;
  logic [7:0] run_ff;
  logic [7:0] quiet_ff;
  logic       sent_ff;
  logic       last_ff;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fmt_ff   <= 8'h00;
      feat_ff  <= 8'h00;
      run_ff   <= 8'h00;
      quiet_ff <= 8'h00;
      sent_ff  <= 1'b0;
      last_ff  <= 1'b1;
    end else begin
      if (reg_wr && reg_addr == 3'h3) fmt_ff <= reg_wdata;
      if (reg_wr && reg_addr == 3'h2 && fmt_ff[7]) feat_ff <= reg_wdata;
      if (reg_wr && ((reg_addr == 3'h0 && !fmt_ff[7]) || (reg_addr == 3'h3 && reg_wdata[6]))) sent_ff <= 1'b1;
      last_ff  <= serial_out;
      run_ff   <= (serial_out != last_ff) ? 8'h01 : run_ff + {7'h00, run_ff != 8'hff};
      // Runs cut by a break are legal, so they are skipped
      quiet_ff <= fmt_ff[6] ? 8'h00 : quiet_ff + {7'h00, quiet_ff != 8'hff};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_fmt_rb; reg_rd && reg_addr == 3'h3 |=> reg_rdata == fmt_ff; endproperty
  a_fmt_rb: assert property (p_fmt_rb) else $error("format readback wrong");
  property p_rd_zero; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data not idle");
  property p_hidden; reg_rd && reg_addr inside {3'h1, 3'h2} && !fmt_ff[7] |=> reg_rdata == 8'h00; endproperty
  a_hidden: assert property (p_hidden) else $error("divisor side visible");
  property p_feat; reg_rd && reg_addr == 3'h2 && fmt_ff[7] |=> reg_rdata == feat_ff; endproperty
  a_feat: assert property (p_feat) else $error("feature readback wrong");
  property p_unmapped; reg_rd && reg_addr > 3'h4 |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_brk; fmt_ff[6] |-> !serial_out; endproperty
  a_brk: assert property (p_brk) else $error("break not holding line low");
  property p_idle; !sent_ff |-> serial_out; endproperty
  a_idle: assert property (p_idle) else $error("line not idle high");
  // Width cast limits the check to divisors below 128
  property p_min_run; serial_out != last_ff && quiet_ff > run_ff + 8'h04 |-> run_ff >= 8'(2 * DIV_RESET); endproperty
  a_min_run: assert property (p_min_run) else $error("serial bit too short");
  cover property (fmt_ff[6] && !serial_out);
  cover property (reg_rd && reg_addr == 3'h2 && fmt_ff[7]);
  cover property ($fell(serial_out) && !fmt_ff[6]);
endmodule : lfc_line_format_assertions
`default_nettype wire

// ### tb/lfc_remote_station.sv
// Remote serial station: sends frames, samples the transmit line
`timescale 1ns/100ps
`default_nettype none
module lfc_remote_station (
  // Clock
  input  wire logic clock,
  // Line
  input  wire logic serial_out,
  output var  logic serial_in
);
  initial serial_in = 1'b1;
  // LSB first, two clocks a bit; the line then holds the frame's last bit, low after a dead-line frame
  task automatic send_frame(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      serial_in <= f[i];
      @(posedge clock);
    end
  endtask : send_frame
  // Samples on falling edges, clear of the launching edge
  task automatic get_char(input int nb, input bit pe, output logic [7:0] d,
                          output logic p, output logic s, output int hr);
    int n;
    n = 0;
    d = 8'h00;
    p = 1'b0;
    while (serial_out !== 1'b0 && n < 300) begin
      @(negedge clock);
      n++;
    end
    for (int i = 0; i < nb; i++) begin
      repeat (2) @(negedge clock);
      d[i] = serial_out;
    end
    if (pe) begin
      repeat (2) @(negedge clock);
      p = serial_out;
    end
    repeat (2) @(negedge clock);
    s = serial_out & (n < 300);
    hr = 0;
    while (serial_out === 1'b1 && hr < 40) begin
      @(negedge clock);
      hr++;
    end
  endtask : get_char
endmodule : lfc_remote_station
`default_nettype wire

// ### tb/test_uart_line_format_control.sv
// Self-checking bench of the line format block
`timescale 1ns/100ps
`default_nettype none
module test_uart_line_format_control;
  logic        clock;
  logic        rst_b      = 1'b0;
  logic [2:0]  reg_addr   = 3'h0;
  logic [7:0]  reg_wdata  = 8'h00;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic [7:0]  reg_rdata;
  logic        serial_in;
  logic        serial_out;
  logic [7:0]  f;
  logic [7:0]  d;
  logic [7:0]  m;
  logic [7:0]  g;
  logic [11:0] fr;
  logic        gp;
  logic        gs;
  int          nb;
  int          k;
  int          hr;
  int          base;
  int          errors     = 0;
  int          num_checks = 0;
  // Length, stop, parity on, even, forced
  logic [7:0]  fmt_tab [7] = '{8'h00, 8'h09, 8'h1a, 8'h2b, 8'h3b, 8'h07, 8'h04};
  lfc_line_format dut_u (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in(serial_in), .serial_out(serial_out));
  lfc_remote_station peer_u (.clock(clock), .serial_out(serial_out), .serial_in(serial_in));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rc(input logic [2:0] a, input logic [7:0] e, input string n);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    chk(n, reg_rdata, e);
  endtask : rc
  function automatic logic xpar(input logic [7:0] fm, input logic [7:0] v);
    return fm[5] ? !fm[4] : (^v) ^ !fm[4];
  endfunction : xpar
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    chk("idle line", {7'h00, serial_out}, 8'h01);
    rc(3'h3, 8'h00, "format reset");
    rc(3'h2, 8'h00, "feature hidden");
    wr(3'h2, 8'h33);
    wr(3'h3, 8'h80);
    rc(3'h2, 8'h00, "feature ignored");
    wr(3'h2, 8'h5a);
    rc(3'h2, 8'h5a, "feature open");
    rc(3'h0, 8'h01, "divisor low reset");
    wr(3'h1, 8'h12);
    wr(3'h0, 8'h34);
    rc(3'h1, 8'h12, "divisor high");
    rc(3'h0, 8'h34, "divisor low");
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h01);
    wr(3'h3, 8'h00);
    rc(3'h2, 8'h00, "feature closed");
    rc(3'h1, 8'h00, "divisor hidden");
    rc(3'h5, 8'h00, "unmapped");
    // Two characters back to back, so the high run shows the stop length
    for (int i = 0; i < 7; i++) begin
      f = fmt_tab[i];
      nb = 5 + f[1:0];
      m = 8'hff >> (3 - f[1:0]);
      d = 8'h96 + 8'(i * 37);
      wr(3'h3, f);
      fork
        begin
          wr(3'h0, d);
          wr(3'h0, ~d);
        end
        begin
          peer_u.get_char(nb, f[3], g, gp, gs, hr);
          chk("tx data", g, d & m);
          chk("tx parity", {7'h00, gp}, {7'h00, f[3] & xpar(f, d & m)});
          chk("tx stop", {7'h00, gs}, 8'h01);
          k = !f[2] ? 2 : (f[1:0] == 2'h0 ? 3 : 4);
          if (i == 0) base = hr - 2;
          chk("stop length", 8'(hr - k), 8'(base));
          peer_u.get_char(nb, f[3], g, gp, gs, hr);
          chk("tx second", g, ~d & m);
        end
      join
    end
    // Odd passes send a wrong parity bit
    for (int i = 0; i < 14; i++) begin
      f = fmt_tab[i / 2];
      if (i[0] && !f[3]) continue;
      nb = 5 + f[1:0];
      m = 8'hff >> (3 - f[1:0]);
      d = (8'h3c + 8'(i * 29)) & m;
      fr = {3'h0, d, 1'b0};
      k = nb + 1;
      if (f[3]) begin
        fr[k] = xpar(f, d) ^ i[0];
        k++;
      end
      fr[k] = 1'b1;
      wr(3'h3, f);
      peer_u.send_frame(fr, k + 1);
      repeat (12) @(posedge clock);
      rc(3'h4, 8'h61 | {5'h00, i[0], 2'h0}, "rx status");
      rc(3'h0, d, "rx data");
    end
    // Dead line then two unread bytes: error and overrun flags
    wr(3'h3, 8'h03);
    peer_u.send_frame(12'h000, 10);
    peer_u.send_frame(12'hfff, 1);
    repeat (12) @(posedge clock);
    rc(3'h4, 8'h79, "rx line errors");
    rc(3'h0, 8'h00, "rx break data");
    rc(3'h4, 8'h60, "rx flags cleared");
    peer_u.send_frame({3'h1, 8'ha5, 1'b0}, 10);
    peer_u.send_frame({3'h1, 8'h5a, 1'b0}, 10);
    repeat (12) @(posedge clock);
    rc(3'h4, 8'h63, "rx overrun");
    rc(3'h0, 8'h5a, "rx newest");
    // Break must hide a whole all-ones character
    wr(3'h3, 8'h43);
    wr(3'h0, 8'hff);
    @(posedge clock);
    k = 0;
    repeat (40) begin
      @(negedge clock);
      k += serial_out;
    end
    chk("break low", 8'(k), 8'h00);
    rc(3'h3, 8'h43, "break kept");
    wr(3'h3, 8'h03);
    repeat (4) @(negedge clock);
    chk("break cleared", {7'h00, serial_out}, 8'h01);
    test_done();
  end
endmodule : test_uart_line_format_control
bind lfc_line_format lfc_line_format_assertions #(.DIV_RESET(DIV_RESET)) chk_u (.clock(clock), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .serial_in(serial_in), .serial_out(serial_out));
`default_nettype wire
